// ---- hw/adc_seq_pkg.sv ----
// Constants shared by the converter sequencer control logic.
// Assumes a single 40 MHz converter clock and synchronous active-low reset.
package adc_seq_pkg;
   localparam int unsigned CONV_CYCLES_8BIT = 28;
   localparam int unsigned CONV_CYCLES_10BIT = 33;
   localparam int unsigned CHAN_PER_GROUP = 8;
   localparam int unsigned SWEEP_CHANNELS = 16;
   localparam logic [1:0] GROUP_SEL_G15 = 2'h0;
   localparam logic [1:0] GROUP_SEL_G0 = 2'h2;
   localparam logic [1:0] GROUP_SEL_G2 = 2'h1;
   localparam logic [1:0] EXT_NONE = 2'h0;
   localparam logic [1:0] EXT_PIN_ZERO = 2'h1;
   localparam logic [1:0] EXT_PIN_ONE = 2'h2;
   localparam logic [1:0] EXT_OPAMP = 2'h3;
   localparam logic [1:0] SRC_PRIMARY = 2'h0;
   localparam logic [1:0] SRC_GROUP = 2'h1;
   localparam logic [1:0] SRC_EXT_ZERO = 2'h2;
   localparam logic [1:0] SRC_EXT_ONE = 2'h3;
   localparam logic [1:0] MODE_ONE_SHOT = 2'h0;
   localparam logic [1:0] MODE_REPEAT = 2'h1;
   localparam logic [1:0] MODE_MP_SINGLE = 2'h2;
   localparam logic [1:0] MODE_MP_REPEAT = 2'h3;
   localparam logic [9:0] RESULT_RESET = 10'h000;
endpackage : adc_seq_pkg

// ---- hw/adc_sequencer_control.sv ----
// Sequencer and control logic of a successive-approximation converter.
// Assumes the analog core converts while busy and offers its code on adc_code_in.
`timescale 1ns/1ps
`default_nettype none
module adc_sequencer_control #(
   parameter int unsigned NUM_RESULTS = 8
) (
   input wire logic sys_clk_in, // Converter clock, 40 MHz.
   input wire logic rst_n_in, // Synchronous reset, active low.
   input wire logic conversion_start_bit_in, // Software start bit.
   input wire logic [1:0] mode_in, // Operating mode.
   input wire logic resolution_in, // One selects 10-bit results.
   input wire logic sample_hold_enable_in, // Sample-and-hold selection.
   input wire logic trigger_source_select_in, // Zero software, one pin or timer.
   input wire logic hw_trigger_select_in, // One selects the timer trigger.
   input wire logic external_trigger_pin_in, // Asynchronous trigger pin.
   input wire logic motor_timer_b2_irq_in, // Timer counter done pulse, same clock.
   input wire logic dma_mode_enable_in, // DMA operating mode.
   input wire logic multiport_sweep_enable_in, // Multi-port sweep enable.
   input wire logic sweep_group_select_hi_in, // Sweep group field high bit.
   input wire logic sweep_group_select_lo_in, // Sweep group field low bit.
   input wire logic ext_input_select_hi_in, // Extended input field high bit.
   input wire logic ext_input_select_lo_in, // Extended input field low bit.
   input wire logic [2:0] channel_select_in, // Primary channel for single modes.
   input wire logic reference_connect_in, // One connects the ladder to reference.
   input wire logic [9:0] adc_code_in, // Code from the analog core at completion.
   output logic busy_out, // Conversion under way.
   output logic [1:0] analog_source_out, // Primary, group, ext zero or ext one.
   output logic [1:0] group_select_out, // Group feeding the second half.
   output logic [2:0] mux_channel_out, // Channel within the source.
   output logic ext_pin_zero_drive_out, // Route primary input out on ext pin 0.
   output logic ladder_connect_out, // Resistor ladder tied to reference.
   output logic [9:0] result_data_out, // Latest stored result.
   output logic [2:0] result_index_out, // Register index receiving it.
   output logic result_strobe_out, // One-cycle completion pulse.
   output logic irq_out, // Interrupt request pulse.
   output logic dma_req_out // DMA request pulse.
);
   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_ARMED = 2'h1,
      ST_CONVERT = 2'h3
   } state_t;

   state_t state_r;
   logic [2:0] trig_sync_r;
   logic trig_level_r;
   logic [5:0] cycle_r;
   logic [3:0] chan_r;
   logic [1:0] ext_sel;
   logic multiport;
   logic single_sweep;
   logic trigger_event;
   logic restart;
   logic conv_done;
   logic [5:0] conv_len;
   logic [9:0] code_sized;
   logic [2:0] dest_index;
   logic conv_complete;
   logic sweep_last;
   logic one_shot;
   logic irq_wanted;

   function automatic logic [5:0] conv_cycles(input logic ten_bit);
      conv_cycles = ten_bit ? 6'(adc_seq_pkg::CONV_CYCLES_10BIT)
                            : 6'(adc_seq_pkg::CONV_CYCLES_8BIT);
   endfunction : conv_cycles

   assign ext_sel = {ext_input_select_hi_in, ext_input_select_lo_in};
   assign multiport = multiport_sweep_enable_in && mode_in[1];
   assign single_sweep = multiport && (mode_in == adc_seq_pkg::MODE_MP_SINGLE);
   // Without sample-and-hold the same counts are used; no other figure is known.
   assign conv_len = conv_cycles(resolution_in);
   assign conv_done = (state_r == ST_CONVERT) && (cycle_r == conv_len - 6'h01);
   // Pin edge counts once the second and third stages agree on the new level.
   assign trigger_event = trigger_source_select_in &&
      (hw_trigger_select_in ? motor_timer_b2_irq_in
                            : (trig_level_r && !trig_sync_r[1] && !trig_sync_r[2]));
   assign restart = trigger_event && conversion_start_bit_in;

   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         // The pin idles high; a low reset value would fake a falling edge.
         trig_sync_r <= 3'h7;
         trig_level_r <= 1'b1;
      end else begin
         trig_sync_r <= {trig_sync_r[1:0], external_trigger_pin_in};
         if (trig_sync_r[1] == trig_sync_r[2]) begin
            trig_level_r <= trig_sync_r[2];
         end
      end
   end

   // A trigger in the completion cycle wins, so an aborted channel never reports.
   assign conv_complete = conv_done && !restart;
   assign sweep_last = single_sweep && (chan_r == 4'(adc_seq_pkg::SWEEP_CHANNELS - 1));
   assign one_shot = !multiport && (mode_in == adc_seq_pkg::MODE_ONE_SHOT);

   // Sequencer state. Clearing the start bit overrides every other event.
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         state_r <= ST_IDLE;
      end else if (!conversion_start_bit_in) begin
         state_r <= ST_IDLE;
      end else begin
         unique case (state_r)
            ST_IDLE: begin
               state_r <= trigger_source_select_in ? ST_ARMED : ST_CONVERT;
            end
            ST_ARMED: begin
               if (restart) begin
                  state_r <= ST_CONVERT;
               end
            end
            ST_CONVERT: begin
               if (conv_complete && sweep_last) begin
                  // A finished single sweep returns to armed; a new hardware trigger starts it again.
                  state_r <= ST_ARMED;
               end else if (conv_complete && one_shot) begin
                  state_r <= ST_ARMED;
               end
            end
            default: begin
               state_r <= ST_IDLE;
            end
         endcase
      end
   end

   // Conversion timer; a trigger inside a conversion starts the count again.
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         cycle_r <= 6'h00;
      end else if (!conversion_start_bit_in || state_r != ST_CONVERT) begin
         cycle_r <= 6'h00;
      end else if (restart || conv_done) begin
         cycle_r <= 6'h00;
      end else begin
         cycle_r <= cycle_r + 6'h01;
      end
   end

   // Sweep position; the four-bit counter wraps by itself in repeat sweeps.
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         chan_r <= 4'h0;
      end else if (!conversion_start_bit_in || state_r == ST_IDLE) begin
         chan_r <= 4'h0;
      end else if (state_r == ST_CONVERT && restart) begin
         chan_r <= 4'h0;
      end else if (conv_done && multiport) begin
         chan_r <= chan_r + 4'h1;
      end
   end

   assign code_sized = resolution_in ? adc_code_in : {2'h0, adc_code_in[9:2]};
   always_comb begin
      dest_index = channel_select_in;
      if (dma_mode_enable_in) begin
         dest_index = 3'h0;
      end else if (ext_sel == adc_seq_pkg::EXT_PIN_ZERO) begin
         dest_index = 3'h0;
      end else if (ext_sel == adc_seq_pkg::EXT_PIN_ONE) begin
         dest_index = 3'h1;
      end
   end

   // One completion strobe per channel; aborted conversions never raise it.
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         result_strobe_out <= 1'b0;
      end else begin
         result_strobe_out <= conv_complete;
      end
   end

   // Repeat and sweep modes without DMA stay silent; the end-of-sweep interrupt is not built.
   assign irq_wanted = dma_mode_enable_in || (mode_in == adc_seq_pkg::MODE_ONE_SHOT);

   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         irq_out <= 1'b0;
      end else begin
         irq_out <= conv_complete && irq_wanted;
      end
   end

   // The DMA request shares the strobe edge, so the result is already stored.
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         dma_req_out <= 1'b0;
      end else begin
         dma_req_out <= conv_complete && dma_mode_enable_in;
      end
   end

   // The result stands until the next completed channel.
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         result_data_out <= adc_seq_pkg::RESULT_RESET;
      end else if (conv_complete) begin
         result_data_out <= code_sized;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         result_index_out <= 3'h0;
      end else if (conv_complete) begin
         result_index_out <= dest_index;
      end
   end

   // Busy lags the state by one edge, like every other registered output.
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         busy_out <= 1'b0;
      end else begin
         busy_out <= (state_r == ST_CONVERT);
      end
   end

   // The ladder follows software directly; ordering against start is software's duty.
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         ladder_connect_out <= 1'b0;
      end else begin
         ladder_connect_out <= reference_connect_in;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         group_select_out <= adc_seq_pkg::GROUP_SEL_G15;
      end else begin
         group_select_out <= {sweep_group_select_hi_in, sweep_group_select_lo_in};
      end
   end

   // The op-amp output is never driven during a multi-port sweep.
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         ext_pin_zero_drive_out <= 1'b0;
      end else begin
         ext_pin_zero_drive_out <= !multiport && (ext_sel == adc_seq_pkg::EXT_OPAMP);
      end
   end

   // Sweeps walk the primaries, then the group; otherwise the extended field decides.
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         analog_source_out <= adc_seq_pkg::SRC_PRIMARY;
      end else if (multiport) begin
         analog_source_out <= chan_r[3] ? adc_seq_pkg::SRC_GROUP : adc_seq_pkg::SRC_PRIMARY;
      end else begin
         unique case (ext_sel)
            adc_seq_pkg::EXT_PIN_ZERO: analog_source_out <= adc_seq_pkg::SRC_EXT_ZERO;
            adc_seq_pkg::EXT_PIN_ONE: analog_source_out <= adc_seq_pkg::SRC_EXT_ONE;
            adc_seq_pkg::EXT_OPAMP: analog_source_out <= adc_seq_pkg::SRC_EXT_ONE;
            adc_seq_pkg::EXT_NONE: analog_source_out <= adc_seq_pkg::SRC_PRIMARY;
         endcase
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         mux_channel_out <= 3'h0;
      end else if (multiport) begin
         mux_channel_out <= chan_r[2:0];
      end else begin
         mux_channel_out <= channel_select_in;
      end
   end
endmodule : adc_sequencer_control
`default_nettype wire

// ---- test/adc_seq_chk.sv ----
// Port checker for the converter sequencer.
// Assumes it is bound to adc_sequencer_control and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module adc_seq_chk (
   input wire logic sys_clk_in, rst_n_in, conversion_start_bit_in, resolution_in,
   input wire logic dma_mode_enable_in, reference_connect_in, busy_out, ladder_connect_out,
   input wire logic sweep_group_select_hi_in, sweep_group_select_lo_in, result_strobe_out,
   input wire logic irq_out, dma_req_out,
   input wire logic [1:0] mode_in, group_select_out,
   input wire logic [2:0] result_index_out,
   input wire logic [9:0] result_data_out
);
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (!rst_n_in);
   // Saturates so that a long restart never wraps into a falsely short count.
   logic [5:0] len_r;
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in || !busy_out || result_strobe_out) len_r <= 6'h00;
      else if (len_r != 6'h3f) len_r <= len_r + 6'h01;
   end
   sequence s_stopped;
      !conversion_start_bit_in [*4];
   endsequence
   a_strobe_alone: assert property (result_strobe_out |=> !result_strobe_out)
      else $error("strobe longer than one cycle");
   a_req_with_strobe: assert property ((irq_out || dma_req_out) |-> result_strobe_out)
      else $error("request without strobe");
   a_dma_each: assert property (
      result_strobe_out && dma_mode_enable_in |-> irq_out && dma_req_out)
      else $error("missing request at completion");
   a_dma_index: assert property (
      result_strobe_out && dma_mode_enable_in |-> result_index_out == 3'h0)
      else $error("dma result not in register zero");
   a_narrow_result: assert property (
      result_strobe_out && !resolution_in |-> result_data_out[9:8] == 2'h0)
      else $error("narrow result too wide");
   a_ladder_follows: assert property (
      $past(rst_n_in) |-> ladder_connect_out == $past(reference_connect_in))
      else $error("ladder does not follow");
   a_start_needed: assert property ($rose(busy_out) |-> $past(conversion_start_bit_in))
      else $error("conversion without start bit");
   a_stop_idles: assert property (s_stopped |-> !busy_out && !result_strobe_out)
      else $error("busy after stop");
   a_group_field: assert property (busy_out && $past(busy_out) && mode_in[1]
      |-> group_select_out == {sweep_group_select_hi_in, sweep_group_select_lo_in})
      else $error("wrong sweep group");
   a_conv_length: assert property (
      result_strobe_out |-> len_r >= (resolution_in ? 6'h20 : 6'h1b))
      else $error("conversion too short");
endmodule : adc_seq_chk
bind adc_sequencer_control adc_seq_chk chk_u (.*);
`default_nettype wire

// ---- test/adc_front_model.sv ----
// Analog front end and DMA sink facing the sequencer.
// Assumes the code is taken while the selection outputs name the channel.
`timescale 1ns/1ps
`default_nettype none
module adc_front_model (
   input wire logic sys_clk_in, // Converter clock.
   input wire logic [1:0] source_in, // Selected source.
   input wire logic [1:0] group_in, // Selected group.
   input wire logic [2:0] channel_in, // Selected channel.
   input wire logic [2:0] salt_in, // Per-run code salt.
   input wire logic dma_req_in, // Transfer request.
   input wire logic wide_in, // Ten-bit results.
   output logic [9:0] code_out, // Code seen by the core.
   output logic [6:0] bytes_out // Bytes moved so far.
);
   logic [6:0] cnt_r = 7'h00;
   assign code_out = source_in[1] ? {source_in, 5'h15, salt_in}
                                  : {source_in, group_in, channel_in, salt_in};
   always @(posedge sys_clk_in) if (dma_req_in) cnt_r <= cnt_r + (wide_in ? 7'h02 : 7'h01);
   assign bytes_out = cnt_r;
endmodule : adc_front_model
`default_nettype wire

// ---- test/tb_adc_sequencer_control.sv ----
// Self-checking bench for the converter sequencer.
// Assumes the front model supplies codes from the selection outputs.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin error_cnt++; \
   $display("Error %s expected %h seen %h", n, e, g); end end
module tb_adc_sequencer_control;
   logic clk = 0, rst_n = 0, start = 0, res = 0, trigger_source_select = 0, hwt = 0, pin = 1, tmr = 0;
   logic dma = 0, mps = 0, ref_c = 0, busy, stb, dreq, drive, irq;
   logic [1:0] mode = 2'h0, grp = 2'h0, ext = 2'h0, src, gsel;
   logic [2:0] chan = 3'h0, mux, idx, salt = 3'h0;
   logic [9:0] code, data;
   logic [6:0] bytes;
   logic [12:0] exp_q[$], got_e;
   int error_cnt = 0, checks = 0;
   initial forever #12.5 clk = ~clk;
   adc_sequencer_control dut_u (.sys_clk_in(clk), .rst_n_in(rst_n), .conversion_start_bit_in(start),
      .mode_in(mode), .resolution_in(res), .sample_hold_enable_in(1'b1),
      .trigger_source_select_in(trigger_source_select),
      .hw_trigger_select_in(hwt), .external_trigger_pin_in(pin), .motor_timer_b2_irq_in(tmr),
      .dma_mode_enable_in(dma), .multiport_sweep_enable_in(mps), .sweep_group_select_hi_in(grp[1]),
      .sweep_group_select_lo_in(grp[0]), .ext_input_select_hi_in(ext[1]),
      .ext_input_select_lo_in(ext[0]), .channel_select_in(chan), .reference_connect_in(ref_c),
      .adc_code_in(code), .busy_out(busy), .analog_source_out(src), .group_select_out(gsel),
      .mux_channel_out(mux), .ext_pin_zero_drive_out(drive), .ladder_connect_out(),
      .result_data_out(data), .result_index_out(idx), .result_strobe_out(stb), .irq_out(irq),
      .dma_req_out(dreq));
   adc_front_model model_u (.sys_clk_in(clk), .source_in(src), .group_in(gsel), .channel_in(mux),
      .salt_in(salt), .dma_req_in(dreq), .wide_in(res), .code_out(code), .bytes_out(bytes));
   function automatic logic [12:0] note(input logic [1:0] s, g, input logic [2:0] c, i);
      logic [9:0] k;
      k = s[1] ? {s, 5'h15, salt} : {s, g, c, salt};
      return {res ? k : {2'h0, k[9:2]}, i};
   endfunction : note
   task automatic sweep(input int n);
      for (int j = 0; j < n; j++) exp_q.push_back(note({1'b0, j[3]}, grp, j[2:0], 3'h0));
   endtask : sweep
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask : tick
   task automatic drain();
      for (int t = 0; t < 1200 && exp_q.size() > 0; t++) tick(1);
      `CHK("pending", 0, exp_q.size())
      start = 0;
      tick(4);
   endtask : drain
   task automatic end_sim();
      if (error_cnt == 0 && checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : end_sim
   always @(posedge clk) if (stb === 1'b1) begin
      got_e = (exp_q.size() > 0) ? exp_q.pop_front() : 13'h1fff;
      `CHK("result", got_e, {data, idx})
      `CHK("irq", dma | (mode == 2'h0), irq)
   end
   initial begin
      repeat (6000) @(posedge clk);
      error_cnt++;
      end_sim();
   end
   initial begin
      salt = 3'($urandom(20));
      tick(20);
      rst_n = 1;
      ref_c = 1; // Ladder goes up in its own write ahead of start
      tick(2);
      {dma, mode, mps, grp} = {1'b1, 2'h2, 1'b1, 2'h2};
      sweep(16);
      start = 1;
      drain();
      {mode, res, grp, salt} = {2'h3, 1'b1, 2'h1, 3'($urandom())};
      sweep(20);
      start = 1;
      drain();
      `CHK("busy", 1'b0, busy)
      {mode, res, grp, trigger_source_select} = {2'h2, 1'b0, 2'h0, 1'b1};
      pin = 0;
      tick(6);
      pin = 1;
      tick(6);
      `CHK("busy", 1'b0, busy)
      sweep(3);
      sweep(16);
      start = 1;
      for (int k = 0; k < 2; k++) begin
         tick(3);
         pin = 0;
         tick(6);
         pin = 1;
         for (int t = 0; t < 400 && exp_q.size() > 16; t++) tick(1);
         tick(10);
      end
      drain();
      `CHK("bytes", 7'h4b, bytes)
      {dma, mode, mps, ext, hwt, res} = {1'b0, 2'h0, 1'b0, 2'h2, 1'b1, 1'b1};
      chan = 3'($urandom());
      tmr = 1;
      tick(1);
      tmr = 0;
      tick(4);
      `CHK("busy", 1'b0, busy)
      exp_q.push_back(note(adc_seq_pkg::SRC_EXT_ONE, 2'h0, 3'h0, 3'h1));
      start = 1;
      tick(3);
      tmr = 1;
      tick(1);
      tmr = 0;
      drain();
      {ext, trigger_source_select} = {2'h3, 1'b0};
      exp_q.push_back(note(adc_seq_pkg::SRC_EXT_ONE, 2'h0, 3'h0, chan));
      start = 1;
      tick(5);
      `CHK("drive", 1'b1, drive)
      drain();
      end_sim();
   end
endmodule : tb_adc_sequencer_control
`default_nettype wire
